// ===== hw/gofmt_formatter.sv
// Gyro output field formatter: per-axis gyro words, temperatures, sample counter
// and latency, captured on each transmit event and offered big-endian.
// Assumes filtered samples and the transmit event come from logic on clk_sys,
// while the external trigger arrives asynchronously on a pin.

// Summary of operation
// - Rate unit sends the newest sample per axis; older samples are dropped.
// - Rate is 24-bit two's complement, MSB first, LSB 2^-14 deg/s.
// - Incremental angle is 24-bit two's complement, MSB first, LSB 2^-21 deg.
// - Incremental angle sums every sample since last transmission times one millisecond.
// - Average unit sends the sum of samples since last transmission divided by their count, which stops at MAX_SAMPLES.
// - Averaging uses the already low-pass filtered samples.
// - Average uses the angular rate format and scaling.
// - Integrated angle accumulates from reset and clears only on reset.
// - Integrated angle spans minus four to under four degrees and wraps silently.
// - Integrated angle uses the incremental angle format and scaling.
// - Temperature per axis is 16-bit two's complement, MSB first, LSB 2^-8 C.
// - Sample counter increments once per internal 1 kHz sample.
// - Sample counter is unsigned 8-bit and wraps to zero silently.
// - Latency is an unsigned 16-bit word in microseconds.
// - Latency runs from the filtered sample to the external trigger edge.
// - Latency word is sent MSB first, then LSB.
module gofmt_formatter
  import gofmt_pkg::*;
#(
  parameter int unsigned MAX_SAMPLES = 1000
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire gofmt_sample_type sample_in,
  input wire gofmt_unit_type out_unit,
  input wire logic tx_event,
  input wire logic trig_pin_n,
  input wire logic [BSEL_W-1:0] byte_sel,
  output gofmt_fields_type fields,
  output logic fields_valid,
  output logic [7:0] byte_out
);

  // The sample count register cannot hold a cap outside this range.
  if (MAX_SAMPLES < 1 || MAX_SAMPLES >= (1 << NCNT_W))
  begin : g_bad_samples
    $error("MAX_SAMPLES out of range");
  end

  // Saturate a wide signed value to the 24-bit field range.
  function automatic logic [RATE_W-1:0] sat24(input logic signed [ACC_W-1:0] v);
    if (v > $signed({{(ACC_W-RATE_W){1'b0}}, RATE_MAX}))
      sat24 = RATE_MAX;
    else if (v < $signed({{(ACC_W-RATE_W){1'b1}}, RATE_MIN}))
      sat24 = RATE_MIN;
    else
      sat24 = v[RATE_W-1:0];
  endfunction

  // Floor division by the sample rate, so remainders stay in [0, 1000).
  function automatic logic signed [ACC_W-1:0] floor_div(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] q;
    q = v / $signed(ACC_W'(SAMPLES_PER_S));
    if (v < 0 && q * $signed(ACC_W'(SAMPLES_PER_S)) != v)
      q = q - 1;
    floor_div = q;
  endfunction

  logic [AXES-1:0][RATE_W-1:0] last_ff;
  logic [AXES-1:0][ACC_W-1:0] incr_ff;
  logic [AXES-1:0][ACC_W-1:0] sum_ff;
  logic [AXES-1:0][RATE_W-1:0] intg_ff;
  logic [AXES-1:0][ACC_W-1:0] rem_ff;
  logic [AXES-1:0][RATE_W-1:0] gyro_val;
  logic [NCNT_W-1:0] nsamp_ff;
  logic [CNT_W-1:0] cnt_ff;
  gofmt_fields_type fields_ff;
  logic fields_valid_ff;
  logic [7:0] byte_ff;

  // A sample arriving with the transmit event belongs to the next interval.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      nsamp_ff <= '0;
    else if (tx_event)
      nsamp_ff <= NCNT_W'(sample_valid);
    else if (sample_valid && nsamp_ff != NCNT_W'(MAX_SAMPLES))
      nsamp_ff <= nsamp_ff + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= CNT_RST;
    else if (sample_valid)
      cnt_ff <= cnt_ff + 1'b1;
  end

  genvar ax;
  generate
    for (ax = 0; ax < AXES; ax++)
    begin : g_axis
      logic signed [ACC_W-1:0] scaled;
      logic signed [ACC_W-1:0] rate_ext;
      logic signed [ACC_W-1:0] total;
      logic signed [ACC_W-1:0] quot;
      assign rate_ext = ACC_W'($signed(sample_in.rate[ax]));
      assign scaled = rate_ext <<< ANGLE_SHIFT;
      assign total = $signed(rem_ff[ax]) + scaled;
      assign quot = floor_div(total);

      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          last_ff[ax] <= '0;
        else if (sample_valid)
          last_ff[ax] <= sample_in.rate[ax];
      end

      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          incr_ff[ax] <= '0;
          sum_ff[ax] <= '0;
        end
        else if (tx_event)
        begin
          incr_ff[ax] <= sample_valid ? scaled : '0;
          sum_ff[ax] <= sample_valid ? rate_ext : '0;
        end
        else if (sample_valid)
        begin
          incr_ff[ax] <= $signed(incr_ff[ax]) + scaled;
          sum_ff[ax] <= $signed(sum_ff[ax]) + rate_ext;
        end
      end

      // Full-scale 24 bits at 2^-21 deg is exactly [-4, 4) deg, so the
      // natural two's complement wrap is the documented wrap.
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          intg_ff[ax] <= '0;
          rem_ff[ax] <= '0;
        end
        else if (sample_valid)
        begin
          intg_ff[ax] <= intg_ff[ax] + quot[RATE_W-1:0];
          rem_ff[ax] <= total - quot * $signed(ACC_W'(SAMPLES_PER_S));
        end
      end

      always_comb
      begin
        unique case (out_unit)
          GOFMT_UNIT_RATE: gyro_val[ax] = last_ff[ax];
          GOFMT_UNIT_INCR: gyro_val[ax] = sat24(floor_div($signed(incr_ff[ax])));
          GOFMT_UNIT_AVG:
          begin
            if (nsamp_ff == '0)
              gyro_val[ax] = last_ff[ax];
            else
              gyro_val[ax] = sat24($signed(sum_ff[ax]) / $signed(ACC_W'(nsamp_ff)));
          end
          GOFMT_UNIT_INTG: gyro_val[ax] = intg_ff[ax];
          default: gyro_val[ax] = last_ff[ax];
        endcase
      end
    end
  endgenerate

  // Trigger pin: three stages, a level change counts when stages two and three agree.
  logic [2:0] trig_sync_ff;
  logic trig_lvl_ff;
  logic trig_fall;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_sync_ff <= 3'b111;
      trig_lvl_ff <= 1'b1;
    end
    else
    begin
      trig_sync_ff <= {trig_sync_ff[1:0], trig_pin_n};
      if (trig_sync_ff[1] == trig_sync_ff[2])
        trig_lvl_ff <= trig_sync_ff[2];
    end
  end
  assign trig_fall = trig_lvl_ff && trig_sync_ff[1] == trig_sync_ff[2] && !trig_sync_ff[2];

  logic [USDIV_W-1:0] usdiv_ff;
  logic us_tick;
  logic [LAT_W-1:0] age_ff;
  logic [LAT_W-1:0] lat_ff;
  assign us_tick = usdiv_ff == USDIV_W'(US_CYCLES - 1);

  // The microsecond divider restarts with each sample so ticks measure its age.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      usdiv_ff <= '0;
      age_ff <= '0;
    end
    else if (sample_valid)
    begin
      usdiv_ff <= '0;
      age_ff <= '0;
    end
    else
    begin
      usdiv_ff <= us_tick ? '0 : usdiv_ff + 1'b1;
      if (us_tick && age_ff != LAT_MAX)
        age_ff <= age_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lat_ff <= '0;
    else if (trig_fall)
      lat_ff <= age_ff;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fields_ff <= '0;
      fields_valid_ff <= 1'b0;
    end
    else
    begin
      fields_valid_ff <= tx_event;
      if (tx_event)
      begin
        fields_ff.gyro <= gyro_val;
        fields_ff.temp <= sample_in.temp;
        fields_ff.counter <= cnt_ff;
        fields_ff.latency <= lat_ff;
      end
    end
  end

  // Byte 0 is the most significant byte of the whole field record.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      byte_ff <= '0;
    else if (byte_sel < BSEL_W'(BYTES))
      byte_ff <= fields_ff[(BYTES-1-byte_sel)*8 +: 8];
    else
      byte_ff <= '0;
  end

  assign fields = fields_ff;
  assign fields_valid = fields_valid_ff;
  assign byte_out = byte_ff;

  chk_counter_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sample_valid |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("sample counter did not step");
  chk_counter_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !sample_valid |=> $stable(cnt_ff))
    else $error("sample counter moved without a sample");
  chk_rate_latest: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_event && out_unit == GOFMT_UNIT_RATE |=> fields.gyro == $past(last_ff))
    else $error("rate field is not the newest sample");
  chk_accum_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_event && !sample_valid |=> nsamp_ff == '0 && incr_ff == '0 && sum_ff == '0)
    else $error("accumulators not restarted after capture");
  chk_intg_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !sample_valid |=> $stable(intg_ff))
    else $error("integrated angle changed without a sample");
  chk_intg_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> intg_ff == '0)
    else $error("integrated angle not cleared by reset");
  chk_lat_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    trig_fall |=> lat_ff == $past(age_ff))
    else $error("latency not captured at trigger edge");
  chk_lat_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sample_valid |=> age_ff == '0 ##1 (age_ff == '0)[*8])
    else $error("sample age did not restart");
  chk_fields_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_event |=> fields_valid && fields.temp == $past(sample_in.temp))
    else $error("temperature capture mismatch");
  chk_remainder: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $signed(rem_ff[0]) >= 0 && $signed(rem_ff[0]) < $signed(ACC_W'(SAMPLES_PER_S)))
    else $error("integration remainder out of range");

endmodule

// ===== hw/gofmt_pkg.sv
// Package for the gyro output field formatter: widths, scaling and field layout.
// Assumes a single 40 MHz system clock and a 1 kHz filtered sample strobe.
package gofmt_pkg;

  localparam int unsigned AXES = 3;
  localparam int unsigned RATE_W = 24;
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned LAT_W = 16;
  localparam int unsigned ACC_W = 48;
  localparam int unsigned NCNT_W = 16;
  localparam int unsigned BYTES = 18;
  localparam int unsigned BSEL_W = 5;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int unsigned USDIV_W = 6;

  // Rate LSB is 2^-14 deg/s, angle LSB 2^-21 deg, sample interval 1/1000 s.
  localparam int unsigned SAMPLES_PER_S = 1000;
  localparam int unsigned ANGLE_SHIFT = 7;

  localparam logic [RATE_W-1:0] RATE_MAX = 24'h7fffff;
  localparam logic [RATE_W-1:0] RATE_MIN = 24'h800000;
  localparam logic [LAT_W-1:0] LAT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

  typedef enum logic [3:0] {
    GOFMT_UNIT_RATE = 4'b0001,
    GOFMT_UNIT_INCR = 4'b0010,
    GOFMT_UNIT_AVG  = 4'b0100,
    GOFMT_UNIT_INTG = 4'b1000
  } gofmt_unit_type;

  typedef struct packed {
    logic [AXES-1:0][RATE_W-1:0] rate;
    logic [AXES-1:0][TEMP_W-1:0] temp;
  } gofmt_sample_type;

  typedef struct packed {
    logic [AXES-1:0][RATE_W-1:0] gyro;
    logic [AXES-1:0][TEMP_W-1:0] temp;
    logic [CNT_W-1:0] counter;
    logic [LAT_W-1:0] latency;
  } gofmt_fields_type;

endpackage

// ===== verification/gofmt_host_model.sv
// Host-side reader of the captured measurement record, byte by byte.
// Assumes the formatter answers byte_sel with byte_out one clock later.
module gofmt_host_model
  import gofmt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic fields_valid,
  input wire logic [7:0] byte_out,
  output logic [BSEL_W-1:0] byte_sel,
  output logic [BYTES*8-1:0] pkt,
  output logic pkt_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // An index past the record reads zero, so idle never shows stale data.
  initial
  begin
    byte_sel = 5'h1f;
    pkt = '0;
    pkt_done = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (fields_valid === 1'b1)
      begin
        pkt_done = 1'b0;
        for (int k = 0; k <= BYTES; k++)
        begin
          #2;
          // The byte launched at the edge just passed has settled by now.
          if (k > 0)
            pkt = {pkt[BYTES*8-9:0], byte_out};
          byte_sel = (k < BYTES) ? BSEL_W'(k) : 5'h1f;
          @(posedge clk_sys);
        end
        pkt_done = 1'b1;
      end
    end
  end
endmodule

// ===== verification/gyro_output_field_formatter_bench.sv
// Self-checking bench for the gyro output field formatter.
// Assumes the host model reads every captured record back over byte_sel.
module gyro_output_field_formatter_bench;
  import gofmt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sample_valid = 1'b0;
  logic tx_event = 1'b0;
  logic trig_pin_n = 1'b1;
  gofmt_sample_type sample_in = '0;
  gofmt_unit_type out_unit = GOFMT_UNIT_RATE;
  logic [BSEL_W-1:0] byte_sel;
  gofmt_fields_type fields;
  logic fields_valid;
  logic [7:0] byte_out;
  logic [BYTES*8-1:0] pkt;
  logic pkt_done;
  logic [CNT_W-1:0] exp_cnt = 8'h00;
  logic [LAT_W-1:0] exp_lat = 16'h0000;
  int err_count = 0;
  int tests_run = 0;

  initial forever #12.5 clk_sys = ~clk_sys;

  gofmt_formatter #(.MAX_SAMPLES(16)) u_gofmt_formatter (
    .clk_sys(clk_sys), .rst_n(rst_n), .sample_valid(sample_valid), .sample_in(sample_in),
    .out_unit(out_unit), .tx_event(tx_event), .trig_pin_n(trig_pin_n), .byte_sel(byte_sel),
    .fields(fields), .fields_valid(fields_valid), .byte_out(byte_out));

  gofmt_host_model u_gofmt_host_model (
    .clk_sys(clk_sys), .fields_valid(fields_valid), .byte_out(byte_out),
    .byte_sel(byte_sel), .pkt(pkt), .pkt_done(pkt_done));

  task automatic check(input logic [BYTES*8-1:0] seen, input logic [BYTES*8-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Inputs always change 2 ns after a rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic do_reset(input gofmt_unit_type u);
    rst_n = 1'b0;
    out_unit = u;
    exp_cnt = 8'h00;
    exp_lat = 16'h0000;
    tick(10);
    rst_n = 1'b1;
    tick(1);
  endtask

  task automatic send(input logic [RATE_W-1:0] r, input int n);
    repeat (n)
    begin
      sample_in.rate = {AXES{r}};
      sample_in.temp = {16'h8102, 16'h8101, 16'h8100};
      sample_valid = 1'b1;
      tick(1);
      sample_valid = 1'b0;
      exp_cnt++;
      tick(1);
    end
  endtask

  task automatic capture(input logic [RATE_W-1:0] g);
    gofmt_fields_type e;
    int n;
    e.gyro = {AXES{g}};
    e.temp = sample_in.temp;
    e.counter = exp_cnt;
    e.latency = exp_lat;
    tx_event = 1'b1;
    tick(1);
    tx_event = 1'b0;
    // The capture pulse stands only in the cycle right after the event.
    check(fields_valid, 1);
    check(fields, e);
    // Let the host model clear its done flag from the previous record.
    tick(1);
    n = 0;
    while (pkt_done !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    if (pkt_done !== 1'b1)
    begin
      err_count++;
      test_done();
    end
    check(pkt, e);
    tick(1);
  endtask

  task automatic t_rate();
    do_reset(GOFMT_UNIT_RATE);
    send(24'h000100, 2);
    send(24'hfff000, 1);
    capture(24'hfff000);
    $display("test rate done");
  endtask

  task automatic t_incr();
    do_reset(GOFMT_UNIT_INCR);
    send(24'h0003e8, 4);
    capture(24'h000200);
    send(24'h0003e8, 2);
    capture(24'h000100);
    send(24'hfffc18, 4);
    capture(24'hfffe00);
    send(RATE_MAX, 8);
    capture(RATE_MAX);
    $display("test incremental done");
  endtask

  task automatic t_avg();
    do_reset(GOFMT_UNIT_AVG);
    send(24'h00000a, 1);
    send(24'h000014, 1);
    send(24'h00001e, 1);
    send(24'h000029, 1);
    capture(24'h000019);
    send(24'hfffff9, 1);
    capture(24'hfffff9);
    $display("test average done");
  endtask

  task automatic t_intg();
    do_reset(GOFMT_UNIT_INTG);
    send(24'h0003e8, 4);
    capture(24'h000200);
    send(24'h0003e8, 2);
    capture(24'h000300);
    send(RATE_MAX, 8);
    capture(24'h83156d);
    $display("test integrated done");
  endtask

  task automatic t_cnt_lat();
    do_reset(GOFMT_UNIT_RATE);
    send(24'h000005, 300);
    capture(24'h000005);
    send(24'h000001, 1);
    // The tick count lands well inside the sixth microsecond after sync delay.
    tick(210);
    trig_pin_n = 1'b0;
    tick(20);
    trig_pin_n = 1'b1;
    exp_lat = 16'h0005;
    capture(24'h000001);
    $display("test counter and latency done");
  endtask

  initial
  begin
    t_rate();
    t_incr();
    t_avg();
    t_intg();
    t_cnt_lat();
    test_done();
  end
endmodule
